// ### common/cmd_port_if.sv
/*
 Serial link between host and command port.
 Assumes the bench supplies no clock here; each end samples with its own clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface cmd_port_if;
   logic ce_n;
   logic sck;
   logic din;
   logic dout;
   logic irq_n;
   modport device (input ce_n, input sck, input din, output dout, output irq_n);
   modport host   (output ce_n, output sck, output din, input dout, input irq_n);
endinterface : cmd_port_if
`default_nettype wire

// ### common/cmd_port_pkg.sv
/*
 Shared constants for the serial command port: opcodes, field widths,
 interrupt status bit positions and reset values.
 Assumes both ends compile this package first.
*/
package cmd_port_pkg;
   localparam int unsigned OPCODE_BITS = 8;
   localparam int unsigned DATA_BITS   = 16;

   localparam logic [7:0] OP_FLIGHT_UP   = 8'h00;
   localparam logic [7:0] OP_FLIGHT_DOWN = 8'h01;
   localparam logic [7:0] OP_FLIGHT_DIFF = 8'h02;
   localparam logic [7:0] OP_TEMP       = 8'h03;
   localparam logic [7:0] OP_RESET      = 8'h04;
   localparam logic [7:0] OP_INIT       = 8'h05;
   localparam logic [7:0] OP_CFG_SAVE   = 8'h06;
   localparam logic [7:0] OP_EVT1       = 8'h07;
   localparam logic [7:0] OP_EVT2       = 8'h08;
   localparam logic [7:0] OP_EVT3       = 8'h09;
   localparam logic [7:0] OP_HALT       = 8'h0a;
   localparam logic [7:0] OP_REG_TIMED  = 8'h0b;
   localparam logic [7:0] OP_REG_ON     = 8'h0c;
   localparam logic [7:0] OP_REG_OFF    = 8'h0d;
   localparam logic [7:0] OP_CALIBRATE  = 8'h0e;
   localparam logic [7:0] OP_WR_FIRST   = 8'h30;
   localparam logic [7:0] OP_WR_LAST    = 8'h43;
   localparam logic [7:0] OP_RD_FIRST   = 8'hb0;
   localparam logic [7:0] OP_RD_LAST    = 8'hff;
   localparam logic [7:0] OP_FL_READ    = 8'h90;
   localparam logic [7:0] OP_FL_WRITE   = 8'h10;
   localparam logic [7:0] OP_FL_ERASE   = 8'h13;
   localparam logic [15:0] FLASH_ADDR_MAX = 16'h1fff;

   // Register locations of the port itself (read opcode / write opcode)
   localparam logic [7:0] OP_RD_IRQ_STATUS = 8'hfe;
   localparam logic [7:0] OP_RD_CONTROL    = 8'hb8;
   localparam logic [7:0] OP_WR_CONTROL    = 8'h38;

   // Interrupt status bit positions
   localparam int unsigned IRQ_W         = 16;
   localparam int unsigned IRQ_HALT_BIT  = 0;
   localparam int unsigned IRQ_CASE_BIT  = 1;
   localparam int unsigned IRQ_INIT_BIT  = 3;
   localparam int unsigned IRQ_FLASH_BIT = 4;
   localparam int unsigned IRQ_REG_BIT   = 5;
   localparam int unsigned IRQ_CAL_BIT   = 6;
   localparam int unsigned IRQ_TEMP_BIT  = 11;
   localparam int unsigned IRQ_FLIGHT_BIT = 12;

   // Control register bit positions
   localparam int unsigned CTL_INT_EN_BIT = 0;
   localparam int unsigned CTL_CASE_BIT   = 1;
   localparam logic [15:0] CTL_RESET      = 16'h0000;
   localparam logic [15:0] IRQ_RESET      = 16'h0000;

   // Host register map
   localparam logic [31:0] HOST_CMD_OFS    = 32'h0000_0000;
   localparam logic [31:0] HOST_WDATA_OFS  = 32'h0000_0004;
   localparam logic [31:0] HOST_STATUS_OFS = 32'h0000_0008;
   localparam logic [31:0] HOST_RDATA_OFS  = 32'h0000_000c;
   localparam int unsigned HOST_CMD_GO_BIT   = 31;
   localparam int unsigned HOST_CMD_DATA_BIT = 30;
   localparam int unsigned HOST_CMD_READ_BIT = 29;
   localparam int unsigned SCK_HALF_CYCLES   = 4;
endpackage : cmd_port_pkg

// ### src/cmd_port_device.sv
/*
 Device end: serial slave, opcode decoder, interrupt status and pin,
 case switch tamper input, launch/done hooks to measurement engines.
 Assumes the link pins are asynchronous to clk and synchronised here.
*/
// Notes on behaviour
// R1 - Flags set on event or command done
// R2 - Status read returns then clears set flags
// R3 - Events during status read survive it
// R4 - Interrupt asserted while any flag set
// R5 - Interrupt only when enable bit set
// R6 - Case switch sets control and status flags
// R7 - Host reads status after interrupt
// R8 - Chip enable frames transfer; clock inside
// R9 - Serial clock idles low
// R10 - Input sampled on falling serial edge
// R11 - One clock pulse per bit
// R12 - Opcodes eight bits, MSB first
// R13 - Data sixteen bits, MSB first
// R14 - Execution opcodes 00h to 0Eh decoded
// R15 - Execute after opcode and chip enable release
// R16 - Register opcodes select location by value
// R17 - Flash opcodes take address, even only for read and write; erase accepts an odd address
// R18 - Upstream flight time sets done flag
// R19 - Reset opcode restores configuration, clears status
// R20 - Halt completion sets halt flag
// R21 - Output shifts MSB first on rising edge
`timescale 1ns/1ps
`default_nettype none
module cmd_port_device
   import cmd_port_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   cmd_port_if.device       link,
   input  wire logic        case_switch,
   input  wire logic [14:0] exec_done,
   input  wire logic [15:0] reg_rdata,
   output logic [14:0]      exec_start,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic [7:0]       reg_loc,
   output logic [15:0]      reg_wdata,
   output logic             flash_cmd,
   output logic [7:0]       flash_op,
   output logic [15:0]      flash_addr,
   output logic             flash_addr_err
);
   import cmd_port_pkg::*;

   typedef enum logic [1:0] {ST_OP, ST_DATA, ST_SKIP} phase_e;

   function automatic logic is_read(input logic [7:0] op);
      return op >= OP_RD_FIRST;
   endfunction : is_read

   function automatic logic is_write(input logic [7:0] op);
      return (op >= OP_WR_FIRST) && (op <= OP_WR_LAST);
   endfunction : is_write

   function automatic logic is_flash(input logic [7:0] op);
      return (op == OP_FL_READ) || (op == OP_FL_WRITE) || (op == OP_FL_ERASE);
   endfunction : is_flash

   logic [2:0]  ce_s_q, sck_s_q, din_s_q, case_s_q;
   logic [2:0]  ce_s_d, sck_s_d, din_s_d, case_s_d;
   phase_e      phase_q, phase_d;
   logic [4:0]  cnt_q, cnt_d;
   logic [7:0]  op_q, op_d;
   logic [15:0] sh_q, sh_d;
   logic [15:0] out_q, out_d;
   logic        dout_q, dout_d;
   logic        op_full_q, op_full_d;
   logic        stat_rd_q, stat_rd_d;
   logic [15:0] irq_q, irq_d;
   logic [15:0] ctl_q, ctl_d;
   logic        irq_n_q, irq_n_d;
   logic [14:0] start_q, start_d;
   logic        reg_wr_q, reg_wr_d, reg_rd_q, reg_rd_d;
   logic [7:0]  loc_q, loc_d;
   logic [15:0] wdata_q, wdata_d;
   logic        fl_q, fl_d, fl_err_q, fl_err_d;
   logic [7:0]  fl_op_q, fl_op_d;
   logic [15:0] fl_addr_q, fl_addr_d;

   logic ce_n_s, sck_fall, sck_rise, ce_rise, ce_fall, case_rise;
   logic [15:0] events;

   // Second stage only feeds the edge detectors, first stage read by nothing else
   always_comb
   begin
      ce_s_d   = {ce_s_q[1:0], link.ce_n};
      sck_s_d  = {sck_s_q[1:0], link.sck};
      din_s_d  = {din_s_q[1:0], link.din};
      case_s_d = {case_s_q[1:0], case_switch};
      ce_n_s   = ce_s_q[1];
      ce_rise  = ce_s_q[1] & ~ce_s_q[2];
      ce_fall  = ~ce_s_q[1] & ce_s_q[2];
      sck_fall = ~ce_n_s & ~sck_s_q[1] & sck_s_q[2]; // R8 R10
      sck_rise = ~ce_n_s & sck_s_q[1] & ~sck_s_q[2];
      case_rise = case_s_q[1] & ~case_s_q[2];
   end

   always_comb
   begin
      events = '0;
      events[IRQ_FLIGHT_BIT] = exec_done[OP_FLIGHT_UP[3:0]] | exec_done[OP_FLIGHT_DOWN[3:0]]
                             | exec_done[OP_FLIGHT_DIFF[3:0]] | exec_done[OP_EVT2[3:0]]; // R18
      events[IRQ_TEMP_BIT]  = exec_done[OP_TEMP[3:0]] | exec_done[OP_EVT3[3:0]];
      events[IRQ_INIT_BIT]  = exec_done[OP_INIT[3:0]];
      events[IRQ_FLASH_BIT] = exec_done[OP_CFG_SAVE[3:0]];
      events[IRQ_REG_BIT]   = exec_done[OP_REG_TIMED[3:0]];
      events[IRQ_CAL_BIT]   = exec_done[OP_CALIBRATE[3:0]];
      events[IRQ_HALT_BIT]  = exec_done[OP_HALT[3:0]]; // R20
      events[IRQ_CASE_BIT]  = case_rise; // R6
   end

   always_comb
   begin
      phase_d   = phase_q;
      cnt_d     = cnt_q;
      op_d      = op_q;
      sh_d      = sh_q;
      out_d     = out_q;
      dout_d    = dout_q;
      op_full_d = op_full_q;
      stat_rd_d = stat_rd_q;
      irq_d     = irq_q | events; // R1
      ctl_d     = ctl_q;
      start_d   = '0;
      reg_wr_d  = 1'b0;
      reg_rd_d  = 1'b0;
      loc_d     = loc_q;
      wdata_d   = wdata_q;
      fl_d      = 1'b0;
      fl_op_d   = fl_op_q;
      fl_addr_d = fl_addr_q;
      fl_err_d  = fl_err_q;
      if (ce_fall)
      begin
         phase_d   = ST_OP;
         cnt_d     = '0;
         op_full_d = 1'b0;
      end
      if (sck_fall)
      begin
         sh_d  = {sh_q[14:0], din_s_q[2]}; // R10
         cnt_d = cnt_q + 5'd1; // R11
         if (phase_q == ST_OP && cnt_q == 5'(OPCODE_BITS - 1))
         begin
            op_d      = {sh_q[6:0], din_s_q[2]}; // R12
            op_full_d = 1'b1;
            cnt_d     = '0;
            phase_d   = ST_DATA;
            if (is_read(op_d))
            begin
               loc_d    = op_d; // R16
               reg_rd_d = 1'b1;
               out_d    = (op_d == OP_RD_IRQ_STATUS) ? irq_q :
                          (op_d == OP_RD_CONTROL) ? ctl_q : reg_rdata;
               if (op_d == OP_RD_IRQ_STATUS)
               begin
                  stat_rd_d = 1'b1;
                  irq_d     = events; // R2 R3
               end
            end
         end
         else if (phase_q == ST_DATA && cnt_q == 5'(DATA_BITS - 1))
         begin
            cnt_d   = '0;
            phase_d = ST_SKIP;
            if (is_write(op_q))
            begin
               loc_d     = op_q; // R16
               wdata_d   = {sh_q[14:0], din_s_q[2]}; // R13
               reg_wr_d  = 1'b1;
               if (op_q == OP_WR_CONTROL)
                  ctl_d  = {sh_q[14:0], din_s_q[2]};
            end
            else if (is_flash(op_q))
            begin
               fl_d      = 1'b1; // R17
               fl_op_d   = op_q;
               fl_addr_d = {sh_q[14:0], din_s_q[2]};
               fl_err_d  = (fl_addr_d > FLASH_ADDR_MAX) || (op_q != OP_FL_ERASE && fl_addr_d[0]);
            end
         end
      end
      if (sck_rise && phase_q == ST_DATA && is_read(op_q))
      begin
         dout_d = out_q[15]; // R21
         out_d  = {out_q[14:0], 1'b0};
      end
      if (ce_rise)
      begin
         stat_rd_d = 1'b0;
         dout_d    = 1'b0;
         if (op_full_q && phase_q == ST_DATA && op_q <= OP_CALIBRATE)
         begin
            start_d[op_q[3:0]] = 1'b1; // R14 R15
            if (op_q == OP_RESET)
            begin
               irq_d = IRQ_RESET; // R19
               ctl_d = CTL_RESET;
            end
         end
      end
      if (case_rise)
         ctl_d[CTL_CASE_BIT] = 1'b1; // R6
      // Interrupt pin low while any flag set and enabled
      irq_n_d = ~(ctl_q[CTL_INT_EN_BIT] & (|irq_q)); // R4 R5
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ce_s_q    <= 3'h7;
         sck_s_q   <= 3'h0; // R9
         din_s_q   <= 3'h0;
         case_s_q  <= 3'h0;
         phase_q   <= ST_OP;
         cnt_q     <= '0;
         op_q      <= '0;
         sh_q      <= '0;
         out_q     <= '0;
         dout_q    <= 1'b0;
         op_full_q <= 1'b0;
         stat_rd_q <= 1'b0;
         irq_q     <= IRQ_RESET;
         ctl_q     <= CTL_RESET;
         irq_n_q   <= 1'b1;
         start_q   <= '0;
         reg_wr_q  <= 1'b0;
         reg_rd_q  <= 1'b0;
         loc_q     <= '0;
         wdata_q   <= '0;
         fl_q      <= 1'b0;
         fl_op_q   <= '0;
         fl_addr_q <= '0;
         fl_err_q  <= 1'b0;
      end
      else
      begin
         ce_s_q    <= ce_s_d;
         sck_s_q   <= sck_s_d;
         din_s_q   <= din_s_d;
         case_s_q  <= case_s_d;
         phase_q   <= phase_d;
         cnt_q     <= cnt_d;
         op_q      <= op_d;
         sh_q      <= sh_d;
         out_q     <= out_d;
         dout_q    <= dout_d;
         op_full_q <= op_full_d;
         stat_rd_q <= stat_rd_d;
         irq_q     <= irq_d;
         ctl_q     <= ctl_d;
         irq_n_q   <= irq_n_d;
         start_q   <= start_d;
         reg_wr_q  <= reg_wr_d;
         reg_rd_q  <= reg_rd_d;
         loc_q     <= loc_d;
         wdata_q   <= wdata_d;
         fl_q      <= fl_d;
         fl_op_q   <= fl_op_d;
         fl_addr_q <= fl_addr_d;
         fl_err_q  <= fl_err_d;
      end
   end

   assign link.dout      = dout_q;
   assign link.irq_n     = irq_n_q;
   assign exec_start     = start_q;
   assign reg_wr         = reg_wr_q;
   assign reg_rd         = reg_rd_q;
   assign reg_loc        = loc_q;
   assign reg_wdata      = wdata_q;
   assign flash_cmd      = fl_q;
   assign flash_op       = fl_op_q;
   assign flash_addr     = fl_addr_q;
   assign flash_addr_err = fl_err_q;
endmodule : cmd_port_device
`default_nettype wire

// ### src/cmd_port_host.sv
/*
 Host end: APB slave registers drive one serial transfer per command,
 opcode then optional 16-bit word, with a divided serial clock.
 Assumes the device samples din on falling sck and shifts dout on rising.
*/
`timescale 1ns/1ps
`default_nettype none
module cmd_port_host
   import cmd_port_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   cmd_port_if.host         link,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq_seen
);
   import cmd_port_pkg::*;

   typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_END} hstate_e;

   hstate_e     st_q, st_d;
   logic [2:0]  div_q, div_d;
   logic [4:0]  bits_q, bits_d;
   logic [23:0] tx_q, tx_d;
   logic [15:0] rx_q, rx_d;
   logic        rd_q, rd_d;
   logic [15:0] wd_q, wd_d;
   logic        ce_n_q, ce_n_d, sck_q, sck_d, din_q, din_d;
   logic [31:0] prdata_q, prdata_d;
   logic        pready_q, pready_d, perr_q, perr_d;
   logic [1:0]  dout_s_q, dout_s_d, irq_s_q, irq_s_d;
   logic        irq_q, irq_d;

   always_comb
   begin
      dout_s_d = {dout_s_q[0], link.dout};
      irq_s_d  = {irq_s_q[0], link.irq_n};
      irq_d    = ~irq_s_q[1];
      st_d = st_q;
      div_d = div_q;
      bits_d = bits_q;
      tx_d = tx_q;
      rx_d = rx_q;
      rd_d = rd_q;
      wd_d = wd_q;
      ce_n_d = ce_n_q;
      sck_d = sck_q;
      din_d = din_q;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      perr_d = 1'b0;
      if (psel && penable && !pready_q)
      begin
         pready_d = 1'b1;
         if (!pwrite && paddr == HOST_STATUS_OFS)
            prdata_d = {30'h0, irq_q, st_q != H_IDLE};
         else if (!pwrite && paddr == HOST_RDATA_OFS)
            prdata_d = {16'h0, rx_q};
         else if (!(pwrite && (paddr == HOST_CMD_OFS || paddr == HOST_WDATA_OFS)))
            perr_d = 1'b1;
      end
      // Writes land on the edge that completes the access, not the one before
      if (psel && penable && pready_q && pwrite)
      begin
         if (paddr == HOST_WDATA_OFS)
            wd_d = pwdata[15:0];
         else if (paddr == HOST_CMD_OFS && pwdata[HOST_CMD_GO_BIT] && st_q == H_IDLE)
         begin
            tx_d   = {pwdata[7:0], wd_q}; // R12 R13
            bits_d = pwdata[HOST_CMD_DATA_BIT] ? 5'd24 : 5'd8;
            rd_d   = pwdata[HOST_CMD_READ_BIT];
            ce_n_d = 1'b0; // R8
            din_d  = pwdata[7];
            div_d  = '0;
            st_d   = H_LOW;
         end
      end
      unique case (st_q)
         H_IDLE:
            sck_d = 1'b0; // R9
         H_LOW:
         begin
            div_d = div_q + 3'd1;
            if (div_q == 3'(SCK_HALF_CYCLES - 1))
            begin
               div_d = '0;
               sck_d = 1'b1;
               st_d  = H_HIGH;
               // Device output trails sck by two synchronisers; take it just before the next rise
               if (rd_q && bits_q < 5'd16)
                  rx_d = {rx_q[14:0], dout_s_q[1]}; // R21
            end
         end
         H_HIGH:
         begin
            div_d = div_q + 3'd1;
            if (div_q == 3'(SCK_HALF_CYCLES - 1))
            begin
               div_d  = '0;
               sck_d  = 1'b0; // R10 R11
               tx_d   = {tx_q[22:0], 1'b0};
               din_d  = tx_q[22];
               bits_d = bits_q - 5'd1;
               st_d   = (bits_q == 5'd1) ? H_END : H_LOW;
            end
         end
         H_END:
         begin
            div_d = div_q + 3'd1;
            if (div_q == 3'(SCK_HALF_CYCLES - 1))
            begin
               ce_n_d = 1'b1; // R8 R15
               st_d   = H_IDLE;
               if (rd_q)
                  rx_d = {rx_q[14:0], dout_s_q[1]}; // R21
            end
         end
         default: st_d = H_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_q <= H_IDLE;
         div_q <= '0;
         bits_q <= '0;
         tx_q <= '0;
         rx_q <= '0;
         rd_q <= 1'b0;
         wd_q <= '0;
         ce_n_q <= 1'b1;
         sck_q <= 1'b0;
         din_q <= 1'b0;
         prdata_q <= '0;
         pready_q <= 1'b0;
         perr_q <= 1'b0;
         dout_s_q <= '0;
         irq_s_q <= 2'h3;
         irq_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         div_q <= div_d;
         bits_q <= bits_d;
         tx_q <= tx_d;
         rx_q <= rx_d;
         rd_q <= rd_d;
         wd_q <= wd_d;
         ce_n_q <= ce_n_d;
         sck_q <= sck_d;
         din_q <= din_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         perr_q <= perr_d;
         dout_s_q <= dout_s_d;
         irq_s_q <= irq_s_d;
         irq_q <= irq_d;
      end
   end

   assign link.ce_n = ce_n_q;
   assign link.sck  = sck_q;
   assign link.din  = din_q;
   assign prdata    = prdata_q;
   assign pready    = pready_q;
   assign pslverr   = perr_q;
   assign irq_seen  = irq_q;
endmodule : cmd_port_host
`default_nettype wire

// ### tb/cmd_port_properties.sv
/*
 Link checker: framing, clock phases, bit counts.
 Assumes sck is made by the host from the same clk.
*/
`timescale 1ns/1ps
`default_nettype none
module cmd_port_properties (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce_n,
   input wire logic sck,
   input wire logic din,
   input wire logic dout,
   input wire logic irq_n
);
   logic       sck_q;
   logic [5:0] bits_q;
   logic [5:0] bits_d;

   // Falling edges counted per frame
   always_comb
   begin
      bits_d = ce_n ? 6'h00 : bits_q + {5'h00, sck_q & ~sck};
   end

   always_ff @(posedge clk)
   begin
      sck_q  <= rst_n ? sck : 1'b0;
      bits_q <= rst_n ? bits_d : 6'h00;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   idle_clock_low_a: assert property (ce_n |-> !sck)
      else $error("serial clock high outside a frame");
   fall_in_frame_a: assert property ($fell(sck) |-> !$past(ce_n))
      else $error("serial clock fell without chip enable");
   frame_end_low_a: assert property ($rose(ce_n) |-> !$past(sck) && !$past(sck, 4))
      else $error("frame closed too soon after last clock");
   high_phase_a: assert property ($rose(sck) |=> sck [*3] ##1 !sck)
      else $error("serial clock high phase not four cycles");
   low_phase_a: assert property ($fell(sck) |=> !sck [*3])
      else $error("serial clock low phase too short");
   din_stable_a: assert property (sck && $past(sck) |-> $stable(din))
      else $error("data in moved while clock high");
   bit_count_a: assert property ($rose(ce_n) |-> bits_q == 6'd8 || bits_q == 6'd24)
      else $error("frame holds neither 8 nor 24 bits");
   frame_hold_a: assert property ($fell(ce_n) |=> !ce_n [*8])
      else $error("frame ended before any bit");
endmodule : cmd_port_properties
`default_nettype wire

// ### tb/tb_spi_command_port_with_irq_status.sv
/*
 Bench: APB on host end drives framed commands into device end.
 Assumes host answers APB within a few cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_spi_command_port_with_irq_status;
   import cmd_port_pkg::*;
   logic        clk         = 1'b0;
   logic        rst_n       = 1'b0;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [31:0] paddr       = 32'h0;
   logic [31:0] pwdata      = 32'h0;
   logic        case_switch = 1'b0;
   logic [14:0] exec_done   = 15'h0;
   logic [15:0] reg_rdata   = 16'h0;
   logic [14:0] seen_start  = 15'h0;
   logic [7:0]  seen_loc    = 8'h0;
   logic [15:0] seen_wdata  = 16'h0;
   logic [7:0]  seen_rd_loc = 8'h0;
   int          n_flash     = 0;
   logic [31:0] prdata, q;
   logic        pready, pslverr, irq_seen, err;
   logic [14:0] exec_start;
   logic        reg_wr, reg_rd, flash_cmd, flash_addr_err;
   logic [7:0]  reg_loc, flash_op;
   logic [15:0] reg_wdata, flash_addr, rd;
   int          n_fail = 0;
   int          samples_checked = 0;

   cmd_port_if link ();
   cmd_port_host i_cmd_port_host (.clk(clk), .rst_n(rst_n), .link(link), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_seen(irq_seen));
   cmd_port_device i_cmd_port_device (.clk(clk), .rst_n(rst_n), .link(link), .case_switch(case_switch),
      .exec_done(exec_done), .reg_rdata(reg_rdata), .exec_start(exec_start), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_loc(reg_loc), .reg_wdata(reg_wdata), .flash_cmd(flash_cmd),
      .flash_op(flash_op), .flash_addr(flash_addr), .flash_addr_err(flash_addr_err));
   cmd_port_properties i_cmd_port_properties (.clk(clk), .rst_n(rst_n), .ce_n(link.ce_n), .sck(link.sck),
      .din(link.din), .dout(link.dout), .irq_n(link.irq_n));

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   // Pulses are one cycle wide, so latch them
   always @(posedge clk)
   begin
      if (|exec_start === 1'b1) seen_start <= exec_start;
      if (reg_wr === 1'b1) seen_loc <= reg_loc;
      if (reg_wr === 1'b1) seen_wdata <= reg_wdata;
      if (reg_rd === 1'b1) seen_rd_loc <= reg_loc;
      if (flash_cmd === 1'b1) n_flash <= n_flash + 1;
   end

   task automatic complete_run();
      if (n_fail == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run

   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         n_fail++;
      end
   endtask : check

   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only pready or the watchdog ends a wait
      do
         @(posedge clk);
      while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // One framed command; busy polled so no fixed link latency assumed
   task automatic xfer(input logic [7:0] op, input logic word, input logic cap, input logic [15:0] wd);
      logic [31:0] r;
      apb(1'b1, HOST_WDATA_OFS, {16'h0, wd}, r);
      apb(1'b1, HOST_CMD_OFS, {1'b1, word, cap, 21'h0, op}, r);
      r = 32'h1;
      while (r[0] !== 1'b0)
         apb(1'b0, HOST_STATUS_OFS, 32'h0, r);
      apb(1'b0, HOST_RDATA_OFS, 32'h0, r);
      rd = r[15:0];
      repeat (12) @(posedge clk);
   endtask : xfer

   task automatic pulse(input int idx);
      @(posedge clk);
      exec_done <= 15'h0001 << idx;
      @(posedge clk);
      exec_done <= 15'h0000;
      repeat (10) @(posedge clk);
   endtask : pulse

   task automatic flash(input logic [7:0] op, input logic [15:0] a, input logic e);
      int k;
      k = n_flash;
      xfer(op, 1'b1, 1'b0, a);
      check("flash_cmd", 16'(k + 1), 16'(n_flash));
      check("flash_op", {8'h0, op}, {8'h0, flash_op});
      check("flash_addr", a, flash_addr);
      check("flash_addr_err", {15'h0, e}, {15'h0, flash_addr_err});
   endtask : flash

   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      xfer(OP_WR_CONTROL, 1'b1, 1'b0, 16'h0001);
      xfer(OP_RD_CONTROL, 1'b1, 1'b1, 16'h0000);
      check("control", 16'h0001, rd);
      for (int op = 0; op < 15; op++)
      begin
         xfer(8'(op), 1'b0, 1'b0, 16'h0000);
         check("exec_start", {1'b0, 15'h0001 << op}, {1'b0, seen_start});
      end
      xfer(OP_WR_CONTROL, 1'b1, 1'b0, 16'h0001);
      pulse(0);
      check("irq_n", 16'h0000, {15'h0, link.irq_n});
      check("irq_seen", 16'h0001, {15'h0, irq_seen});
      xfer(OP_RD_IRQ_STATUS, 1'b1, 1'b1, 16'h0);
      check("irq_status", 16'h0001 << IRQ_FLIGHT_BIT, rd);
      check("irq_n", 16'h0001, {15'h0, link.irq_n});
      // Halt lands while the data word of a status read shifts
      fork
         xfer(OP_RD_IRQ_STATUS, 1'b1, 1'b1, 16'h0);
         begin
            repeat (120) @(posedge clk);
            pulse(10);
         end
      join
      xfer(OP_RD_IRQ_STATUS, 1'b1, 1'b1, 16'h0);
      check("irq_status", 16'h0001 << IRQ_HALT_BIT, rd);
      @(posedge clk);
      case_switch <= 1'b1;
      repeat (12) @(posedge clk);
      check("irq_n", 16'h0000, {15'h0, link.irq_n});
      xfer(OP_RD_IRQ_STATUS, 1'b1, 1'b1, 16'h0);
      check("irq_status", 16'h0001 << IRQ_CASE_BIT, rd);
      xfer(OP_RD_CONTROL, 1'b1, 1'b1, 16'h0);
      check("control", 16'h0003, rd);
      case_switch <= 1'b0;
      xfer(OP_WR_CONTROL, 1'b1, 1'b0, 16'h0000);
      pulse(3);
      check("irq_n", 16'h0001, {15'h0, link.irq_n});
      xfer(OP_RD_IRQ_STATUS, 1'b1, 1'b1, 16'h0);
      check("irq_status", 16'h0001 << IRQ_TEMP_BIT, rd);
      pulse(14);
      xfer(OP_RESET, 1'b0, 1'b0, 16'h0);
      xfer(OP_RD_IRQ_STATUS, 1'b1, 1'b1, 16'h0);
      check("irq_status", 16'h0000, rd);
      xfer(OP_WR_FIRST, 1'b1, 1'b0, 16'h1234);
      check("reg_loc", {8'h0, OP_WR_FIRST}, {8'h0, seen_loc});
      check("reg_wdata", 16'h1234, seen_wdata);
      xfer(OP_WR_LAST, 1'b1, 1'b0, 16'hedcb);
      check("reg_loc", {8'h0, OP_WR_LAST}, {8'h0, seen_loc});
      check("reg_wdata", 16'hedcb, seen_wdata);
      reg_rdata <= 16'hc35a;
      xfer(OP_RD_FIRST, 1'b1, 1'b1, 16'h0);
      check("reg_read", 16'hc35a, rd);
      check("reg_rd_loc", {8'h0, OP_RD_FIRST}, {8'h0, seen_rd_loc});
      flash(OP_FL_READ, 16'h0100, 1'b0);
      flash(OP_FL_WRITE, 16'h0101, 1'b1);
      flash(OP_FL_ERASE, 16'h2000, 1'b1);
      apb(1'b0, 32'h0000_0010, 32'h0, q);
      check("pslverr", 16'h0001, {15'h0, err});
      complete_run();
   end

   initial
   begin
      repeat (80000) @(posedge clk);
      n_fail++;
      complete_run();
   end
endmodule : tb_spi_command_port_with_irq_status
`default_nettype wire
